// *** design/scwt_top.sv ***
// system counter, per-core timers and memory-mapped wakeup timer
`timescale 1ns/1ns
// What this block does
// - counter ticks at 10 MHz or faster
// - count never wraps within ten years
// - count width between 56 and 64 bits
// - scaling support forces full 64-bit count
// - count delivered to every active per-core timer
// - per-core compare raises private core interrupt
// - always-on timer interrupts always; its core count output is frozen while its core is off
// - separate wakeup timer when cores lose power
// - per-core state saved or kept always on
// - wakeup timer uses separate register frames
// - wakeup expiry drives shared interrupt line
// - wakeup expiry also wakes processors
// - virtual offset reads zero, writes ignored
// - no user-level view frame provided
// - wakeup timer reachable from non-secure space
// - frame security mapping per frame
// - power controller wake on expiry, irq still
module scwt_top
	import scwt_pkg::*;
#(
	parameter int NPE       = scwt_pkg::NUM_PE,
	parameter int TICK_DIV  = 12,
	parameter bit SCALING   = 1'b1
) (
	input  wire logic                        CLK_SYS_I,
	input  wire logic                        RST_I,
	input  wire logic                        ACC_VLD_I,
	input  wire logic                        ACC_WR_I,
	input  wire logic                        ACC_NS_I,
	input  wire logic [1:0]                  ACC_FRAME_I,
	input  wire logic [2:0]                  ACC_WORD_I,
	input  wire logic [31:0]                 ACC_WDATA_I,
	output logic                             ACC_RVLD_O,
	output logic [31:0]                      ACC_RDATA_O,
	output logic                             ACC_ERR_O,
	input  wire logic [NPE-1:0]              PE_ON_I,
	input  wire logic [NPE-1:0]              PE_CMP_WE_I,
	input  wire logic [NPE*scwt_pkg::CNT_W-1:0] PE_CMP_I,
	input  wire logic [NPE-1:0]              PE_CTL_WE_I,
	input  wire logic [NPE-1:0]              PE_EN_I,
	output logic [NPE*scwt_pkg::CNT_W-1:0]   PE_CNT_O,
	output logic [NPE-1:0]                   PER_CORE_PRIVATE_INTERRUPT_O,
	output logic [NPE-1:0]                   PE_STAT_O,
	input  wire logic                        WAKE_ON_EXPIRY_I,
	output logic                             WAKEUP_SHARED_IRQ_O,
	output logic                             PWR_WAKE_REQ_O,
	output logic [scwt_pkg::CNT_W-1:0]       SYS_CNT_O
);
	import scwt_pkg::*;

	// tick rate and ten-year headroom checked at elaboration
	localparam int TICK_MHZ = CLK_MHZ / TICK_DIV;
	localparam longint TEN_YR_TICKS =
		longint'(TEN_YEAR_SEC) * longint'(TICK_MHZ) * 64'd1000000;
	localparam int DIV_W = $clog2(TICK_DIV + 1);

	if (TICK_DIV < 1 || TICK_MHZ < CNT_MIN_MHZ) begin : g_bad_rate
		$error("counter tick below minimum rate");
	end
	if (SCALING && CNT_W != CNT_W_MAX) begin : g_bad_scale
		$error("scaling needs a 64-bit count");
	end
	if (CNT_W < CNT_W_MIN || CNT_W > CNT_W_MAX) begin : g_bad_w
		$error("count width out of range");
	end
	if (CNT_W < 64
		&& TEN_YR_TICKS >= (longint'(1) <<< CNT_W)) begin : g_wrap
		$error("count would wrap within ten years");
	end
	if (NPE < 1) begin : g_bad_npe
		$error("need at least one core timer");
	end

	// tick divider from the system clock
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	wire              tick;
	logic             cnt_en_q;
	logic [CNT_W-1:0] cnt;

	assign tick  = (div_q == DIV_W'(TICK_DIV - 1));
	assign div_d = tick ? '0 : div_q + DIV_W'(1);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I)
			div_q <= '0;
		else
			div_q <= div_d;
	end

	scwt_sys_counter #(
		.W      (CNT_W)
	) u_cnt (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.en_i   (tick && cnt_en_q),
		.cnt_o  (cnt)
	);

	// per-core timers, always fed the count; core count outputs update only when their core is on
	logic [NPE*CNT_W-1:0] pe_cnt_q;
	logic [NPE-1:0]       pe_irq;
	logic [NPE-1:0]       pe_stat;
	logic [NPE-1:0]       pe_irq_q;
	logic [NPE-1:0]       pe_stat_q;

	for (genvar g = 0; g < NPE; g++) begin : g_pe
		// core timers sit on always-on logic here, so state survives
		scwt_cmp_timer #(
			.W        (CNT_W)
		) u_pe (
			.clk_i    (CLK_SYS_I),
			.rst_i    (RST_I),
			.cnt_i    (cnt),
			.cmp_we_i (PE_CMP_WE_I[g]),
			.cmp_i    (PE_CMP_I[g*CNT_W +: CNT_W]),
			.ctl_we_i (PE_CTL_WE_I[g]),
			.en_i     (PE_EN_I[g]),
			.mask_i   (1'b0),
			.cmp_o    (),
			.en_o     (),
			.mask_o   (),
			.stat_o   (pe_stat[g]),
			.irq_o    (pe_irq[g])
		);
		always_ff @(posedge CLK_SYS_I) begin
			if (RST_I)
				pe_cnt_q[g*CNT_W +: CNT_W] <= '0;
			else if (PE_ON_I[g])
				pe_cnt_q[g*CNT_W +: CNT_W] <= cnt;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pe_irq_q  <= '0;
			pe_stat_q <= '0;
		end else begin
			pe_irq_q  <= pe_irq;
			pe_stat_q <= pe_stat;
		end
	end

	// frame decode with per-frame security
	wire acc_rd   = ACC_VLD_I && !ACC_WR_I;
	wire acc_wr   = ACC_VLD_I && ACC_WR_I;
	wire f_cctl   = ACC_FRAME_I == FRM_CNT_CTRL;
	wire f_cread  = ACC_FRAME_I == FRM_CNT_READ;
	wire f_tctl   = ACC_FRAME_I == FRM_TMR_CTRL;
	wire f_ptmr   = ACC_FRAME_I == FRM_PER_TMR;
	// counter-read frame not provided; per-timer frame non-secure only
	wire deny     = (f_cctl && ACC_NS_I) || f_cread
		|| (f_ptmr && !ACC_NS_I);
	wire ok_wr    = acc_wr && !deny;
	wire w_cmp_lo = ok_wr && f_ptmr && ACC_WORD_I == W_CMP_LO;
	wire w_cmp_hi = ok_wr && f_ptmr && ACC_WORD_I == W_CMP_HI;
	wire w_ctl    = ok_wr && f_ptmr && ACC_WORD_I == W_CTL;
	wire w_cctl   = ok_wr && f_cctl && ACC_WORD_I == W_CTL;

	// wakeup timer
	logic [CNT_W-1:0] wk_cmp;
	logic             wk_en;
	logic             wk_mask;
	logic             wk_stat;
	logic             wk_irq;
	wire  [CNT_W-1:0] wk_cmp_new = w_cmp_lo
		? {wk_cmp[CNT_W-1:32], ACC_WDATA_I}
		: {ACC_WDATA_I[CNT_W-33:0], wk_cmp[31:0]};

	scwt_cmp_timer #(
		.W        (CNT_W)
	) u_wake (
		.clk_i    (CLK_SYS_I),
		.rst_i    (RST_I),
		.cnt_i    (cnt),
		.cmp_we_i (w_cmp_lo || w_cmp_hi),
		.cmp_i    (wk_cmp_new),
		.ctl_we_i (w_ctl),
		.en_i     (ACC_WDATA_I[CTL_EN_BIT]),
		.mask_i   (ACC_WDATA_I[CTL_MASK_BIT]),
		.cmp_o    (wk_cmp),
		.en_o     (wk_en),
		.mask_o   (wk_mask),
		.stat_o   (wk_stat),
		.irq_o    (wk_irq)
	);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I)
			cnt_en_q <= 1'b1;
		else if (w_cctl)
			cnt_en_q <= ACC_WDATA_I[CCTL_EN_BIT];
	end

	// read mux
	wire [63:0] cnt64 = 64'(cnt);
	wire [63:0] cmp64 = 64'(wk_cmp);
	logic [31:0] rd_w;
	always_comb begin
		rd_w = 32'h0000_0000;
		unique case (ACC_WORD_I)
			W_CNT_LO:  rd_w = cnt64[31:0];
			W_CNT_HI:  rd_w = cnt64[63:32];
			W_CMP_LO:  rd_w = f_ptmr ? cmp64[31:0] : 32'h0000_0000;
			W_CMP_HI:  rd_w = f_ptmr ? cmp64[63:32] : 32'h0000_0000;
			W_CTL: begin
				if (f_ptmr)
					rd_w = {29'h0, wk_stat, wk_mask, wk_en};
				else if (f_cctl)
					rd_w = {30'h0, SCALING, cnt_en_q};
			end
			// virtual offset is read-as-zero; writes dropped
			W_VOFF_LO: rd_w = VOFF_RST[31:0];
			W_VOFF_HI: rd_w = VOFF_RST[63:32];
			default:   rd_w = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ACC_RVLD_O  <= 1'b0;
			ACC_RDATA_O <= '0;
			ACC_ERR_O   <= 1'b0;
		end else begin
			ACC_RVLD_O  <= ACC_VLD_I;
			ACC_RDATA_O <= (acc_rd && !deny) ? rd_w : 32'h0000_0000;
			ACC_ERR_O   <= ACC_VLD_I && deny;
		end
	end

	// interrupt, wake and count outputs, registered
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			WAKEUP_SHARED_IRQ_O <= 1'b0;
			PWR_WAKE_REQ_O      <= 1'b0;
			PE_CNT_O            <= '0;
			SYS_CNT_O           <= '0;
		end else begin
			WAKEUP_SHARED_IRQ_O <= wk_irq;
			PWR_WAKE_REQ_O      <= wk_irq && WAKE_ON_EXPIRY_I;
			PE_CNT_O            <= pe_cnt_q;
			SYS_CNT_O           <= cnt;
		end
	end
	assign PER_CORE_PRIVATE_INTERRUPT_O = pe_irq_q;
	assign PE_STAT_O = pe_stat_q;
	// no user-level view frame; frame codes offer none
endmodule

// *** common/scwt_pkg.sv ***
// shared constants for the system counter and wakeup timer block
package scwt_pkg;
	localparam int          CNT_W_MIN       = 56;
	localparam int          CNT_W_MAX       = 64;
	localparam int          CNT_W           = 64;
	localparam int          CLK_MHZ         = 125;
	localparam int          CNT_MIN_MHZ     = 10;
	localparam logic [63:0] CNT_RST         = 64'h0000_0000_0000_0000;
	localparam logic [63:0] CMP_RST         = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] VOFF_RST        = 64'h0000_0000_0000_0000;
	localparam int          NUM_PE          = 4;
	localparam int          TEN_YEAR_SEC    = 315360000;
	// frame select codes on the access port
	localparam logic [1:0]  FRM_CNT_CTRL    = 2'h0;
	localparam logic [1:0]  FRM_CNT_READ    = 2'h1;
	localparam logic [1:0]  FRM_TMR_CTRL    = 2'h2;
	localparam logic [1:0]  FRM_PER_TMR     = 2'h3;
	// word select within a frame
	localparam logic [2:0]  W_CNT_LO        = 3'h0;
	localparam logic [2:0]  W_CNT_HI        = 3'h1;
	localparam logic [2:0]  W_CMP_LO        = 3'h2;
	localparam logic [2:0]  W_CMP_HI        = 3'h3;
	localparam logic [2:0]  W_CTL           = 3'h4;
	localparam logic [2:0]  W_VOFF_LO       = 3'h5;
	localparam logic [2:0]  W_VOFF_HI       = 3'h6;
	localparam int          CTL_EN_BIT      = 0;
	localparam int          CTL_MASK_BIT    = 1;
	localparam int          CTL_STAT_BIT    = 2;
	localparam int          CCTL_EN_BIT     = 0;
	localparam int          CCTL_SCALE_BIT  = 1;
	typedef enum logic [1:0] {
		SCWT_RSP_OK,
		SCWT_RSP_DENY
	} scwt_rsp_t;
endpackage

// *** design/scwt_sys_counter.sv ***
// system count source, stepping by one on each cycle with en_i set
`timescale 1ns/1ns
module scwt_sys_counter #(
	parameter int W = scwt_pkg::CNT_W
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         en_i,
	output logic [W-1:0]      cnt_o
);
	import scwt_pkg::*;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// a width outside the allowed range stops elaboration
	if (W < CNT_W_MIN || W > CNT_W_MAX) begin : g_bad_w
		$error("counter width out of range");
	end

	assign cnt_d = en_i ? cnt_q + W'(1) : cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= CNT_RST[W-1:0];
		else
			cnt_q <= cnt_d;
	end
	assign cnt_o = cnt_q;
endmodule

// *** design/scwt_cmp_timer.sv ***
// compare timer used for each per-core timer and the wakeup timer
`timescale 1ns/1ns
module scwt_cmp_timer #(
	parameter int W = scwt_pkg::CNT_W
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] cnt_i,
	input  wire logic         cmp_we_i,
	input  wire logic [W-1:0] cmp_i,
	input  wire logic         ctl_we_i,
	input  wire logic         en_i,
	input  wire logic         mask_i,
	output logic [W-1:0]      cmp_o,
	output logic              en_o,
	output logic              mask_o,
	output logic              stat_o,
	output logic              irq_o
);
	import scwt_pkg::*;
	logic [W-1:0] cmp_q;
	logic         en_q;
	logic         mask_q;
	logic         irq_q;
	wire          hit;

	assign hit = en_q && (cnt_i >= cmp_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_q  <= CMP_RST[W-1:0];
			en_q   <= 1'b0;
			mask_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			if (cmp_we_i)
				cmp_q <= cmp_i;
			if (ctl_we_i) begin
				en_q   <= en_i;
				mask_q <= mask_i;
			end
			// level stays until compare rewritten, timer disabled or interrupt masked
			irq_q <= hit && !mask_q;
		end
	end
	assign cmp_o  = cmp_q;
	assign en_o   = en_q;
	assign mask_o = mask_q;
	assign stat_o = hit;
	assign irq_o  = irq_q;
endmodule

// *** sim/scwt_top_asserts.sv ***
// port-level assertions for the counter and wakeup timer top
`timescale 1ns/1ns
module scwt_top_asserts #(
	parameter int NPE      = 4,
	parameter int TICK_DIV = 12,
	parameter bit SCALING  = 1'b1
) (
	input  wire logic                           CLK_SYS_I,
	input  wire logic                           RST_I,
	input  wire logic                           ACC_VLD_I,
	input  wire logic                           ACC_WR_I,
	input  wire logic                           ACC_NS_I,
	input  wire logic [1:0]                     ACC_FRAME_I,
	input  wire logic [2:0]                     ACC_WORD_I,
	input  wire logic                           ACC_RVLD_O,
	input  wire logic [31:0]                    ACC_RDATA_O,
	input  wire logic                           ACC_ERR_O,
	input  wire logic [NPE-1:0]                 PE_ON_I,
	input  wire logic [NPE*scwt_pkg::CNT_W-1:0] PE_CNT_O,
	input  wire logic [scwt_pkg::CNT_W-1:0]     SYS_CNT_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	a_resp_one_cycle: assert property (ACC_VLD_I |=> ACC_RVLD_O)
		else $error("no response one cycle after access");
	a_no_extra_resp: assert property (!ACC_VLD_I |=> !ACC_RVLD_O)
		else $error("response without access");
	a_ctrl_secure_only: assert property (ACC_VLD_I && ACC_FRAME_I == 2'h0
		&& ACC_NS_I |=> ACC_ERR_O && ACC_RDATA_O == 32'h0)
		else $error("non-secure counter control access not refused");
	a_read_frame_absent: assert property (ACC_VLD_I
		&& ACC_FRAME_I == 2'h1 |=> ACC_ERR_O)
		else $error("counter read frame access not refused");
	a_timer_frame_ns: assert property (ACC_VLD_I && ACC_FRAME_I == 2'h3
		&& !ACC_NS_I |=> ACC_ERR_O)
		else $error("secure per-timer frame access not refused");
	a_tmr_ctl_both: assert property (ACC_VLD_I
		&& ACC_FRAME_I == 2'h2 |=> !ACC_ERR_O)
		else $error("timer control frame access refused");
	a_voff_reads_zero: assert property (ACC_VLD_I && !ACC_WR_I
		&& ACC_FRAME_I == 2'h2 && ACC_WORD_I inside {3'h5, 3'h6}
		|=> ACC_RDATA_O == 32'h0)
		else $error("virtual offset read not zero");
	a_cnt_step_one: assert property (!$stable(SYS_CNT_O)
		|-> SYS_CNT_O == $past(SYS_CNT_O) + 64'h1)
		else $error("count step not one");
	a_tick_spacing: assert property (!$stable(SYS_CNT_O)
		|=> $stable(SYS_CNT_O)[*8])
		else $error("count ticks too close together");
	// two register stages lie between the power input and the output
	a_off_core_frozen: assert property (!$past(PE_ON_I[0], 2)
		|-> $stable(PE_CNT_O[63:0]))
		else $error("count moved for powered-down core");
endmodule
bind scwt_top scwt_top_asserts #(.NPE(NPE), .TICK_DIV(TICK_DIV),
	.SCALING(SCALING)) scwt_top_asserts_i (.CLK_SYS_I(CLK_SYS_I),
	.RST_I(RST_I), .ACC_VLD_I(ACC_VLD_I), .ACC_WR_I(ACC_WR_I),
	.ACC_NS_I(ACC_NS_I), .ACC_FRAME_I(ACC_FRAME_I),
	.ACC_WORD_I(ACC_WORD_I), .ACC_RVLD_O(ACC_RVLD_O),
	.ACC_RDATA_O(ACC_RDATA_O), .ACC_ERR_O(ACC_ERR_O), .PE_ON_I(PE_ON_I),
	.PE_CNT_O(PE_CNT_O), .SYS_CNT_O(SYS_CNT_O));

// *** sim/scwt_irqc_model.sv ***
// interrupt and power controller model facing the wakeup timer
`timescale 1ns/1ns
module scwt_irqc_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic wake_arm_i,
	input  wire logic spi_i,
	input  wire logic wake_req_i,
	output logic      wake_on_expiry_o,
	output int        spi_seen_o,
	output int        wake_seen_o
);
	// level programming, held as long as software leaves it armed
	assign wake_on_expiry_o = wake_arm_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spi_seen_o  <= 0;
			wake_seen_o <= 0;
		end else begin
			spi_seen_o  <= spi_seen_o + int'(spi_i);
			wake_seen_o <= wake_seen_o + int'(wake_req_i);
		end
	end
endmodule

// *** sim/system_counter_wakeup_timer_tb.sv ***
// self-checking bench for the counter and wakeup timer
`timescale 1ns/1ns
module system_counter_wakeup_timer_tb;
	import scwt_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         vld = 1'b0;
	logic         wr = 1'b0;
	logic         ns = 1'b0;
	logic [1:0]   frm = 2'h0;
	logic [2:0]   wrd = 3'h0;
	logic [31:0]  wdat = 32'h0;
	logic [3:0]   pe_on = 4'hF;
	logic [3:0]   cmp_we = 4'h0;
	logic [255:0] pe_cmp = '1;
	logic [3:0]   ctl_we = 4'h0;
	logic [3:0]   pe_en = 4'h0;
	logic         arm = 1'b0;
	logic         rvld, err, wsi, wreq, woe;
	logic [31:0]  rdat;
	logic [255:0] pe_cnt;
	logic [3:0]   per_core_private_interrupt, pst;
	logic [63:0]  cnt, c0;
	int           errors = 0;
	int           num_checks = 0;
	int           cyc = 0;
	int           spi_n, wk_n;

	scwt_top scwt_top_i (.CLK_SYS_I(clk), .RST_I(rst), .ACC_VLD_I(vld),
		.ACC_WR_I(wr), .ACC_NS_I(ns), .ACC_FRAME_I(frm), .ACC_WORD_I(wrd),
		.ACC_WDATA_I(wdat), .ACC_RVLD_O(rvld), .ACC_RDATA_O(rdat),
		.ACC_ERR_O(err), .PE_ON_I(pe_on), .PE_CMP_WE_I(cmp_we),
		.PE_CMP_I(pe_cmp), .PE_CTL_WE_I(ctl_we), .PE_EN_I(pe_en),
		.PE_CNT_O(pe_cnt), .PER_CORE_PRIVATE_INTERRUPT_O(per_core_private_interrupt),
		.PE_STAT_O(pst), .WAKE_ON_EXPIRY_I(woe),
		.WAKEUP_SHARED_IRQ_O(wsi), .PWR_WAKE_REQ_O(wreq), .SYS_CNT_O(cnt));
	scwt_irqc_model scwt_irqc_model_i (.clk_i(clk), .rst_i(rst),
		.wake_arm_i(arm), .spi_i(wsi), .wake_req_i(wreq),
		.wake_on_expiry_o(woe), .spi_seen_o(spi_n), .wake_seen_o(wk_n));

	always #4 clk = ~clk;
	// whole run is well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			test_done();
		end
	end

	task test_done;
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string n, input logic [63:0] e, input logic [63:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask

	task acc(input logic w, n, input logic [1:0] f, input logic [2:0] d,
		input logic [31:0] wd, input logic e_err, crd, input logic [31:0] e);
		@(posedge clk);
		vld <= 1'b1;
		wr <= w;
		ns <= n;
		frm <= f;
		wrd <= d;
		wdat <= wd;
		@(posedge clk);
		vld <= 1'b0;
		#1;
		chk("rvld", 64'h1, {63'h0, rvld});
		chk("err", {63'h0, e_err}, {63'h0, err});
		if (crd)
			chk("rdata", {32'h0, e}, {32'h0, rdat});
	endtask

	task wait_irq;
		for (int i = 0; i < 80 && wsi !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task t_rate;
		@(posedge clk);
		#1;
		c0 = cnt;
		repeat (120) @(posedge clk);
		#1;
		chk("count rate", c0 + 64'hA, cnt);
		acc(1'b1, 1'b1, FRM_CNT_CTRL, W_CTL, 32'h0, 1'b1, 1'b1, 32'h0);
		acc(1'b0, 1'b0, FRM_CNT_CTRL, W_CTL, 32'h0, 1'b0, 1'b1, 32'h3);
		acc(1'b1, 1'b0, FRM_CNT_CTRL, W_CTL, 32'h0, 1'b0, 1'b0, 32'h0);
		@(posedge clk);
		#1;
		c0 = cnt;
		repeat (30) @(posedge clk);
		#1;
		chk("count stopped", c0, cnt);
		acc(1'b1, 1'b0, FRM_CNT_CTRL, W_CTL, 32'h1, 1'b0, 1'b0, 32'h0);
	endtask

	task t_frames;
		logic e;
		for (int f = 0; f < 4; f++) begin
			for (int n = 0; n < 2; n++) begin
				e = (f == 0 && n == 1) || f == 1 || (f == 3 && n == 0);
				acc(1'b0, n[0], f[1:0], W_CTL, 32'h0, e, 1'b1,
					(f == 0 && !e) ? 32'h3 : 32'h0);
			end
		end
		acc(1'b0, 1'b1, FRM_PER_TMR, W_CMP_LO, 32'h0, 1'b0, 1'b1, 32'hFFFFFFFF);
		acc(1'b0, 1'b1, FRM_PER_TMR, W_CNT_HI, 32'h0, 1'b0, 1'b1, 32'h0);
		acc(1'b1, 1'b1, FRM_TMR_CTRL, W_VOFF_LO, 32'hFFFFFFFF, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 1'b1, FRM_TMR_CTRL, W_VOFF_LO, 32'h0, 1'b0, 1'b1, 32'h0);
		acc(1'b0, 1'b0, FRM_TMR_CTRL, W_VOFF_HI, 32'h0, 1'b0, 1'b1, 32'h0);
	endtask

	task t_wake;
		@(posedge clk);
		arm <= 1'b1;
		c0 = cnt + 64'h3;
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CMP_LO, c0[31:0], 1'b0, 1'b0, 32'h0);
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CMP_HI, c0[63:32], 1'b0, 1'b0, 32'h0);
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CTL, 32'h1, 1'b0, 1'b0, 32'h0);
		chk("early irq", 64'h0, {63'h0, wsi});
		wait_irq();
		chk("wake irq", 64'h1, {63'h0, wsi});
		repeat (30) @(posedge clk);
		#1;
		chk("irq held", 64'h1, {63'h0, wsi});
		chk("wake req", 64'h1, {63'h0, wreq});
		chk("spi seen", 64'h1, {63'h0, spi_n > 0});
		chk("wake seen", 64'h1, {63'h0, wk_n > 0});
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CTL, 32'h3, 1'b0, 1'b0, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		chk("irq masked", 64'h0, {63'h0, wsi});
		acc(1'b0, 1'b1, FRM_PER_TMR, W_CTL, 32'h0, 1'b0, 1'b1, 32'h7);
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CTL, 32'h1, 1'b0, 1'b0, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		chk("irq unmasked", 64'h1, {63'h0, wsi});
		acc(1'b0, 1'b1, FRM_PER_TMR, W_CTL, 32'h0, 1'b0, 1'b1, 32'h5);
		acc(1'b1, 1'b1, FRM_PER_TMR, W_CTL, 32'h0, 1'b0, 1'b0, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		chk("irq cleared", 64'h0, {63'h0, wsi});
	endtask

	task t_core;
		@(posedge clk);
		pe_on <= 4'hE;
		repeat (2) @(posedge clk);
		#1;
		c0 = pe_cnt[63:0];
		@(posedge clk);
		pe_cmp[127:64] <= cnt + 64'h3;
		cmp_we <= 4'h2;
		ctl_we <= 4'h2;
		pe_en <= 4'h2;
		@(posedge clk);
		cmp_we <= 4'h0;
		ctl_we <= 4'h0;
		#1;
		chk("core early", 64'h0, {63'h0, per_core_private_interrupt[1]});
		for (int i = 0; i < 80 && per_core_private_interrupt[1] !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("core irq", 64'h1, {63'h0, per_core_private_interrupt[1]});
		chk("core0 quiet", 64'h0, {63'h0, per_core_private_interrupt[0]});
		chk("off core frozen", c0, pe_cnt[63:0]);
		chk("core stat", 64'h2, {60'h0, pst});
		// core count trails the system count output by one register
		c0 = cnt;
		@(posedge clk);
		#1;
		chk("on core count", c0, pe_cnt[127:64]);
	endtask

	initial begin
		repeat (9) @(posedge clk);
		#1;
		chk("reset count", 64'h0, cnt);
		chk("reset irq", 64'h0, {63'h0, wsi});
		@(posedge clk);
		rst <= 1'b0;
		t_rate();
		t_frames();
		t_wake();
		t_core();
		test_done();
	end
endmodule
